// [sewp_device.sv]
// memory end of the two-wire link: decode, acknowledge, page write, timed programming
// Functional notes
// RQ1: 512 pages of 128 bytes, 16-bit address
// RQ2: sample on scl rise, drive after fall
// RQ3: data changes only while scl low
// RQ4: sda fall with scl high starts command
// RQ5: sda rise with scl high is stop
// RQ6: acknowledge each accepted byte on ninth clock
// RQ7: idle after reset and after stop
// RQ8: controller recovers bus with nine clocks
// RQ9: selection word: type, straps, direction bit
// RQ10: compare chip select bits with straps
// RQ11: direction 1 reads, 0 writes
// RQ12: mismatch gives no ack, returns idle
// RQ13: write protect high blocks array modification
// RQ14: write: selection, address, data, stop
// RQ15: timed programming after stop, inputs ignored
// RQ16: only in-page offset advances per byte
// RQ17: offset wraps to start of page
// RQ18: partial pages program only received bytes
// RQ19: id page write uses type 1011b
// RQ20: id page offset from address bits 6..0
// RQ21: locked id page: no data ack
// RQ22: polling acked only after programming done
// RQ23: protected writes acked, programming skipped
`timescale 1ns/1ps
module sewp_device
  import sewp_pkg::*;
#(
  parameter int PROG_CYCLES_P = NV_PROGRAM_CYCLES
) (
  input wire logic REF_CLK,
  input wire logic RST_B,
  sewp_if.dev BUS,
  input wire logic [2:0] CHIP_SELECT_STRAPS,
  input wire logic WRITE_PROTECT,
  output logic BUSY,
  output logic ID_LOCKED
);
  localparam int PCW = $clog2(PROG_CYCLES_P + 1);
  if (PROG_CYCLES_P < PAGE_BYTES) begin : g_chk
    $error("programming time shorter than one page commit");
  end

  logic scl_f;
  logic sda_f;
  logic wp_f;
  logic [2:0] straps_f;
  // straps are sampled like pins; the bench drives all three from its straps signal
  sewp_sync #(.W(6), .RST_VAL(DEV_SYNC_RST)) u_sync (
    .clk(REF_CLK),
    .rst_b(RST_B),
    .din({CHIP_SELECT_STRAPS, WRITE_PROTECT, BUS.sda, BUS.scl}),
    .dout({straps_f, wp_f, sda_f, scl_f})
  );

  logic [7:0] mem [0:(PAGE_COUNT*PAGE_BYTES)-1];
  logic [7:0] idmem [0:PAGE_BYTES-1];
  logic [7:0] pbuf [0:PAGE_BYTES-1];
  logic [PAGE_BYTES-1:0] pmask_r;
  sewp_dev_state_e state_r;
  logic scl_q_r;
  logic sda_q_r;
  logic [3:0] bit_cnt_r;
  logic in_ack_r;
  logic [7:0] shift_r;
  logic [7:0] tx_r;
  logic sda_oe_r;
  logic [ADDR_W-1:0] addr_r;
  logic id_sel_r;
  logic first_r;
  logic mack_r;
  logic got_data_r;
  logic lock_req_r;
  logic busy_r;
  logic prog_en_r;
  logic prog_id_r;
  logic lock_pend_r;
  logic id_locked_r;
  logic [PCW-1:0] prog_cnt_r;

  assign BUS.dev_sda_o = 1'b0;
  assign BUS.dev_sda_oe = sda_oe_r;
  assign BUSY = busy_r;
  assign ID_LOCKED = id_locked_r;

  wire scl_rise = scl_f && !scl_q_r; // RQ2
  wire scl_fall = !scl_f && scl_q_r;
  wire start_det = scl_f && scl_q_r && sda_q_r && !sda_f; // RQ3 RQ4
  wire stop_det = scl_f && scl_q_r && !sda_q_r && sda_f; // RQ5
  wire [3:0] sel_type = shift_r[7:4];
  wire type_ok = (sel_type == TYPE_ARRAY) || (sel_type == TYPE_IDPAGE); // RQ9 RQ19
  // busy makes polls fail until the cycle ends
  wire sel_ok = type_ok && (shift_r[3:1] == straps_f) && !busy_r; // RQ10 RQ22 RQ15
  wire data_ack = !(id_sel_r && id_locked_r); // RQ21
  wire rx_state = (state_r != ST_READ);
  wire ack_now = (state_r == ST_DEVSEL) ? sel_ok : (state_r == ST_WDATA) ? data_ack : 1'b1;
  wire dec_evt = scl_fall && !in_ack_r && (bit_cnt_r == 4'(BYTE_BITS));
  wire [OFS_W-1:0] ofs = addr_r[OFS_W-1:0];
  wire [OFS_W-1:0] ofs_inc = ofs + 7'h01;
  wire rd_id_now = (state_r == ST_DEVSEL) ? (sel_type == TYPE_IDPAGE) : id_sel_r;
  wire [7:0] rd_byte = rd_id_now ? idmem[ofs] : mem[addr_r];
  wire pbuf_we = dec_evt && (state_r == ST_WDATA) && data_ack;
  wire [OFS_W-1:0] cidx = prog_cnt_r[OFS_W-1:0];
  wire commit_we = busy_r && prog_en_r && (prog_cnt_r < PCW'(PAGE_BYTES)) && pmask_r[cidx];
  wire prog_last = (prog_cnt_r == PCW'(PROG_CYCLES_P - 1));
  // protected array writes never start a cycle
  wire prog_go = stop_det && (state_r == ST_WDATA) && got_data_r && (id_sel_r || !wp_f); // RQ13 RQ23 RQ15

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl_f;
      sda_q_r <= sda_f;
    end
  end

  // link sequencer
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_r <= ST_IDLE; // RQ7
      bit_cnt_r <= 4'h0;
      in_ack_r <= 1'b0;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      sda_oe_r <= 1'b0;
      addr_r <= 16'h0000;
      id_sel_r <= 1'b0;
      first_r <= 1'b0;
      mack_r <= 1'b0;
      got_data_r <= 1'b0;
      lock_req_r <= 1'b0;
      pmask_r <= '0;
    end else if (start_det) begin
      state_r <= ST_DEVSEL; // RQ4
      bit_cnt_r <= 4'h0;
      in_ack_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (stop_det) begin
      state_r <= ST_IDLE; // RQ5 RQ7
      in_ack_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (state_r != ST_IDLE) begin
      if (scl_rise && !in_ack_r && bit_cnt_r != 4'(BYTE_BITS)) begin
        shift_r <= {shift_r[6:0], sda_f}; // RQ2 RQ1
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end
      if (scl_rise && in_ack_r) mack_r <= !sda_f;
      if (dec_evt) begin
        in_ack_r <= 1'b1;
        sda_oe_r <= rx_state && ack_now; // RQ6 RQ12
        if (!ack_now) state_r <= ST_IDLE; // RQ12 RQ21
        else begin
          unique case (state_r)
            ST_DEVSEL: begin
              id_sel_r <= (sel_type == TYPE_IDPAGE);
              if (shift_r[0]) begin // RQ11
                state_r <= ST_READ;
                first_r <= 1'b1;
                tx_r <= rd_byte;
                addr_r <= addr_r + 16'h0001;
              end else state_r <= ST_ADRH;
            end
            ST_ADRH: begin
              addr_r[15:8] <= shift_r; // RQ1
              state_r <= ST_ADRL;
            end
            ST_ADRL: begin
              addr_r[7:0] <= shift_r; // RQ20
              got_data_r <= 1'b0;
              lock_req_r <= 1'b0;
              pmask_r <= '0;
              state_r <= ST_WDATA; // RQ14
            end
            ST_WDATA: begin
              pmask_r[ofs] <= 1'b1; // RQ18
              got_data_r <= 1'b1;
              addr_r[OFS_W-1:0] <= ofs_inc; // RQ16 RQ17
              if (id_sel_r && addr_r[ID_SEL_ADDR_BIT] && shift_r[LOCK_DATA_BIT]) lock_req_r <= 1'b1;
            end
            ST_READ: begin
            end
            ST_IDLE: begin
            end
          endcase
        end
      end else if (scl_fall && in_ack_r) begin
        in_ack_r <= 1'b0;
        bit_cnt_r <= 4'h0;
        sda_oe_r <= 1'b0;
        if (state_r == ST_READ) begin
          if (first_r) begin
            first_r <= 1'b0;
            sda_oe_r <= !tx_r[7]; // RQ2
          end else if (mack_r) begin
            tx_r <= rd_byte;
            addr_r <= addr_r + 16'h0001;
            sda_oe_r <= !rd_byte[7];
          end else state_r <= ST_IDLE;
        end
      end else if (scl_fall && state_r == ST_READ) begin
        tx_r <= {tx_r[6:0], 1'b0};
        sda_oe_r <= !tx_r[6]; // RQ3
      end
    end
  end

  // self-timed programming; the page buffer drains one byte per cycle
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      busy_r <= 1'b0;
      prog_cnt_r <= '0;
      prog_en_r <= 1'b0;
      prog_id_r <= 1'b0;
      lock_pend_r <= 1'b0;
      id_locked_r <= 1'b0;
    end else if (busy_r) begin
      prog_cnt_r <= prog_cnt_r + PCW'(1);
      if (prog_last) begin
        busy_r <= 1'b0; // RQ15 RQ7
        if (lock_pend_r) id_locked_r <= 1'b1;
      end
    end else if (prog_go) begin
      busy_r <= 1'b1; // RQ15
      prog_cnt_r <= '0;
      prog_id_r <= id_sel_r;
      // the lock request writes no page data
      prog_en_r <= !(id_sel_r && lock_req_r);
      lock_pend_r <= id_sel_r && lock_req_r;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (pbuf_we) pbuf[ofs] <= shift_r;
  end

  always_ff @(posedge REF_CLK) begin
    if (commit_we) begin
      if (prog_id_r) idmem[cidx] <= pbuf[cidx]; // RQ20
      else mem[{addr_r[ADDR_W-1:OFS_W], cidx}] <= pbuf[cidx]; // RQ16 RQ18
    end
  end
endmodule

// [sewp_pkg.sv]
// shared constants and types for the two-wire memory write port
package sewp_pkg;
  localparam int ADDR_W = 16;
  localparam int PAGE_BYTES = 128;
  localparam int PAGE_COUNT = 512;
  localparam int OFS_W = 7;
  localparam int BYTE_BITS = 8;
  localparam int ID_SEL_ADDR_BIT = 10;
  localparam int LOCK_DATA_BIT = 1;
  localparam int RECOVER_PULSES = 9;
  localparam logic [3:0] TYPE_ARRAY = 4'ha;
  localparam logic [3:0] TYPE_IDPAGE = 4'hb;
  localparam int REF_CLK_MHZ = 50;
  localparam int NV_PROGRAM_CYCLE_TIME_US = 3000;
  localparam int NV_PROGRAM_CYCLES = NV_PROGRAM_CYCLE_TIME_US * REF_CLK_MHZ;
  localparam int SCL_FREQ_KHZ = 1000;
  localparam int SCL_QTR_CYCLES = (REF_CLK_MHZ * 1000 + 4 * SCL_FREQ_KHZ - 1) / (4 * SCL_FREQ_KHZ);
  localparam logic [5:0] DEV_SYNC_RST = 6'h03;
  localparam logic [0:0] HOST_SYNC_RST = 1'h1;
  typedef enum logic [2:0] {CMD_START, CMD_STOP, CMD_WRITE, CMD_READ, CMD_RECOVER} sewp_cmd_e;
  typedef enum {ST_IDLE, ST_DEVSEL, ST_ADRH, ST_ADRL, ST_WDATA, ST_READ} sewp_dev_state_e;
  typedef enum {HS_IDLE, HS_START, HS_STOP, HS_BIT, HS_RECOV} sewp_host_state_e;
endpackage

// [sewp_if.sv]
// two-wire link between controller and memory, open-drain data line
`timescale 1ns/1ps
interface sewp_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;
  // pulled high unless someone drives low
  assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));
  modport dev(input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport host(output scl, output host_sda_o, output host_sda_oe, input sda);
endinterface

// [sewp_sync.sv]
// three-stage input synchroniser with agree filter
`timescale 1ns/1ps
module sewp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] f_r;
  assign dout = f_r;
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        s1_r[i] <= RST_VAL[i];
        s2_r[i] <= RST_VAL[i];
        s3_r[i] <= RST_VAL[i];
        f_r[i] <= RST_VAL[i];
      end else begin
        s1_r[i] <= din[i];
        s2_r[i] <= s1_r[i];
        s3_r[i] <= s2_r[i];
        // single-cycle glitches never reach the filtered level
        if (s2_r[i] == s3_r[i]) f_r[i] <= s3_r[i];
      end
    end
  end
endmodule

// [sewp_host.sv]
// controller end of the two-wire link: byte-level command engine
`timescale 1ns/1ps
module sewp_host
  import sewp_pkg::*;
#(
  parameter int SCL_QTR_P = SCL_QTR_CYCLES
) (
  input wire logic REF_CLK,
  input wire logic RST_B,
  sewp_if.host BUS,
  input wire logic CMD_VALID,
  input wire sewp_cmd_e CMD_CODE,
  input wire logic [7:0] CMD_DATA,
  input wire logic CMD_LAST,
  output logic CMD_READY,
  output logic RSP_VALID,
  output logic [7:0] RSP_DATA,
  output logic RSP_ACK
);
  // the memory needs several samples per level through its filter
  if (SCL_QTR_P < 6) begin : g_chk
    $error("quarter period too short for the memory input filter");
  end
  localparam int QW = $clog2(SCL_QTR_P + 1);

  logic sda_f;
  sewp_sync #(.W(1), .RST_VAL(HOST_SYNC_RST)) u_sync (
    .clk(REF_CLK),
    .rst_b(RST_B),
    .din(BUS.sda),
    .dout(sda_f)
  );

  sewp_host_state_e state_r;
  logic [QW-1:0] qcnt_r;
  logic [1:0] phase_r;
  logic [3:0] bit_r;
  logic scl_r;
  logic sda_oe_r;
  logic [7:0] shift_r;
  logic rd_r;
  logic last_r;
  logic ack_r;
  logic ready_r;
  logic rsp_valid_r;
  logic [7:0] rsp_data_r;
  logic rsp_ack_r;

  assign BUS.scl = scl_r;
  assign BUS.host_sda_o = 1'b0;
  assign BUS.host_sda_oe = sda_oe_r;
  assign CMD_READY = ready_r;
  assign RSP_VALID = rsp_valid_r;
  assign RSP_DATA = rsp_data_r;
  assign RSP_ACK = rsp_ack_r;

  wire tick = (qcnt_r == QW'(SCL_QTR_P - 1));
  wire accept = CMD_VALID && ready_r;
  wire ack_slot = (bit_r == 4'(BYTE_BITS));
  wire bit_drive_low = ack_slot ? (rd_r && !last_r) : (!rd_r && !shift_r[7]);
  wire recov_done = sda_f || (bit_r == 4'(RECOVER_PULSES - 1));

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_r <= HS_IDLE;
      qcnt_r <= '0;
      phase_r <= 2'h0;
      bit_r <= 4'h0;
      scl_r <= 1'b1;
      sda_oe_r <= 1'b0;
      shift_r <= 8'h00;
      rd_r <= 1'b0;
      last_r <= 1'b0;
      ack_r <= 1'b0;
      ready_r <= 1'b1;
      rsp_valid_r <= 1'b0;
      rsp_data_r <= 8'h00;
      rsp_ack_r <= 1'b0;
    end else begin
      rsp_valid_r <= 1'b0;
      qcnt_r <= (state_r == HS_IDLE || tick) ? '0 : qcnt_r + QW'(1);
      if (accept) begin
        ready_r <= 1'b0;
        phase_r <= 2'h0;
        bit_r <= 4'h0;
        shift_r <= CMD_DATA; // RQ9 RQ14 RQ19
        rd_r <= (CMD_CODE == CMD_READ);
        last_r <= CMD_LAST;
        unique case (CMD_CODE)
          CMD_START: state_r <= HS_START;
          CMD_STOP: state_r <= HS_STOP;
          CMD_WRITE, CMD_READ: state_r <= HS_BIT;
          CMD_RECOVER: state_r <= HS_RECOV;
          default: state_r <= HS_IDLE;
        endcase
      end else if (tick && state_r != HS_IDLE) begin
        phase_r <= phase_r + 2'h1;
        unique case (state_r)
          HS_START: begin
            unique case (phase_r)
              2'h0: sda_oe_r <= 1'b0;
              2'h1: scl_r <= 1'b1;
              2'h2: sda_oe_r <= 1'b1; // RQ4
              2'h3: begin
                scl_r <= 1'b0;
                state_r <= HS_IDLE;
                ready_r <= 1'b1;
                rsp_valid_r <= 1'b1;
              end
            endcase
          end
          HS_STOP: begin
            unique case (phase_r)
              2'h0: sda_oe_r <= 1'b1;
              2'h1: scl_r <= 1'b1;
              2'h2: begin
                sda_oe_r <= 1'b0; // RQ5
                state_r <= HS_IDLE;
                ready_r <= 1'b1;
                rsp_valid_r <= 1'b1;
              end
              2'h3: state_r <= HS_IDLE;
            endcase
          end
          HS_BIT: begin
            unique case (phase_r)
              2'h0: sda_oe_r <= bit_drive_low; // RQ3
              2'h1: scl_r <= 1'b1;
              2'h2: begin
                if (ack_slot) ack_r <= !sda_f; // RQ6
                else shift_r <= {shift_r[6:0], sda_f};
              end
              2'h3: begin
                scl_r <= 1'b0;
                bit_r <= bit_r + 4'h1;
                // free the line with the last data bit so the acknowledge never meets our drive
                if (!ack_slot && !rd_r && bit_r == 4'(BYTE_BITS - 1)) sda_oe_r <= 1'b0; // RQ6
                if (ack_slot) begin
                  sda_oe_r <= 1'b0;
                  state_r <= HS_IDLE;
                  ready_r <= 1'b1;
                  rsp_valid_r <= 1'b1;
                  rsp_data_r <= shift_r;
                  rsp_ack_r <= ack_r;
                end
              end
            endcase
          end
          HS_RECOV: begin
            unique case (phase_r)
              2'h0: sda_oe_r <= 1'b0;
              2'h1: scl_r <= 1'b1;
              2'h2: begin
                if (recov_done) begin
                  rsp_ack_r <= sda_f; // RQ8
                  state_r <= HS_START;
                  phase_r <= 2'h0;
                end
              end
              2'h3: begin
                scl_r <= 1'b0;
                bit_r <= bit_r + 4'h1;
              end
            endcase
          end
          HS_IDLE: begin
          end
        endcase
      end
    end
  end
endmodule

// [sewp_asserts.sv]
// link checker: data line behaviour against the serial clock
`timescale 1ns/1ps
module sewp_asserts (
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic scl,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic sda
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_B);

  sequence s_start;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence s_stop;
    scl && $past(scl) && $rose(sda);
  endsequence

  property p_dev_od;
    dev_sda_oe |-> !dev_sda_o;
  endproperty
  a_dev_od: assert property (p_dev_od) else $error("device drives data line high");
  property p_host_od;
    host_sda_oe |-> !host_sda_o;
  endproperty
  a_host_od: assert property (p_host_od) else $error("host drives data line high");
  // filter delay keeps device edges well inside the low phase
  property p_dev_edge;
    $changed(dev_sda_oe) |-> !scl && !$past(scl);
  endproperty
  a_dev_edge: assert property (p_dev_edge) else $error("device data change with clock high");
  property p_no_clash;
    dev_sda_oe |-> !host_sda_oe;
  endproperty
  a_no_clash: assert property (p_no_clash) else $error("both ends drive the data line");
  property p_start_quiet;
    s_start |-> !dev_sda_oe [*8];
  endproperty
  a_start_quiet: assert property (p_start_quiet) else $error("device drives after start");
  property p_stop_quiet;
    s_stop |-> (sda && !dev_sda_oe) [*4];
  endproperty
  a_stop_quiet: assert property (p_stop_quiet) else $error("device not idle after stop");
  property p_ack_stands;
    ($rose(scl) && dev_sda_oe) |-> dev_sda_oe throughout (scl [*8]);
  endproperty
  a_ack_stands: assert property (p_ack_stands) else $error("device bit dropped during clock high");
  property p_reset_idle;
    $rose(RST_B) |-> !dev_sda_oe && scl;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("link not idle after reset");
endmodule

// [serial_eeprom_write_port_tb.sv]
// self-checking bench: host and device joined over the two-wire link
`timescale 1ns/1ps
module serial_eeprom_write_port_tb;
  import sewp_pkg::*;
  localparam int PROG_P = 1500;
  localparam logic [2:0] STRAPS = 3'h5;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic cmd_valid = 1'b0;
  sewp_cmd_e cmd_code = CMD_START;
  logic [7:0] cmd_data = 8'h00;
  logic cmd_last = 1'b0;
  logic [2:0] straps = STRAPS;
  logic wp = 1'b0;
  logic cmd_ready;
  logic rsp_valid;
  logic rsp_ack;
  logic busy;
  logic id_locked;
  logic [7:0] rsp_data;
  int failures = 0;
  int checked = 0;
  int busy_run = 0;
  int last_run = 0;

  sewp_if u_sewp_if ();
  sewp_host #(.SCL_QTR_P(13)) u_sewp_host (.REF_CLK(ref_clk), .RST_B(rst_b), .BUS(u_sewp_if.host),
    .CMD_VALID(cmd_valid), .CMD_CODE(cmd_code), .CMD_DATA(cmd_data), .CMD_LAST(cmd_last),
    .CMD_READY(cmd_ready), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .RSP_ACK(rsp_ack));
  sewp_device #(.PROG_CYCLES_P(PROG_P)) u_sewp_device (.REF_CLK(ref_clk), .RST_B(rst_b),
    .BUS(u_sewp_if.dev), .CHIP_SELECT_STRAPS(straps), .WRITE_PROTECT(wp), .BUSY(busy), .ID_LOCKED(id_locked));
  sewp_asserts u_sewp_asserts (.REF_CLK(ref_clk), .RST_B(rst_b), .scl(u_sewp_if.scl),
    .host_sda_o(u_sewp_if.host_sda_o), .host_sda_oe(u_sewp_if.host_sda_oe), .dev_sda_o(u_sewp_if.dev_sda_o),
    .dev_sda_oe(u_sewp_if.dev_sda_oe), .sda(u_sewp_if.sda));

  initial begin
    forever #10 ref_clk = ~ref_clk;
  end

  // sampled off the edge so the busy register has settled
  always @(negedge ref_clk) begin
    if (busy === 1'b1) begin
      busy_run <= busy_run + 1;
    end else if (busy_run != 0) begin
      last_run <= busy_run;
      busy_run <= 0;
    end
  end

  task automatic finish_test();
    if (failures == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one command: held for the accepting edge, then wait for its answer pulse
  task automatic cmd(input sewp_cmd_e code, input logic [7:0] data, input logic last);
    int n;
    check({7'h00, cmd_ready}, 8'h01);
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_code <= code;
    cmd_data <= data;
    cmd_last <= last;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    @(negedge ref_clk);
    check({7'h00, cmd_ready}, 8'h00);
    n = 0;
    while (rsp_valid !== 1'b1 && n < 5000) begin
      @(negedge ref_clk);
      n++;
    end
    check({7'h00, n < 5000}, 8'h01);
  endtask

  task automatic wr(input logic [7:0] b, input logic exp_ack);
    cmd(CMD_WRITE, b, 1'b0);
    check({7'h00, rsp_ack}, {7'h00, exp_ack});
    check(rsp_data, b);
  endtask

  task automatic rd(input logic last, input logic [7:0] exp);
    cmd(CMD_READ, 8'h00, last);
    check(rsp_data, exp);
  endtask

  task automatic head(input logic [3:0] typ, input logic [15:0] addr);
    cmd(CMD_START, 8'h00, 1'b0);
    wr({typ, STRAPS, 1'b0}, 1'b1);
    wr(addr[15:8], 1'b1);
    wr(addr[7:0], 1'b1);
  endtask

  task automatic rd_sel(input logic [3:0] typ);
    cmd(CMD_START, 8'h00, 1'b0);
    wr({typ, STRAPS, 1'b1}, 1'b1);
  endtask

  task automatic busy_on();
    repeat (10) @(negedge ref_clk);
    check({7'h00, busy}, 8'h01);
  endtask

  task automatic busy_off();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 3 * PROG_P) begin
      @(negedge ref_clk);
      n++;
    end
    repeat (2) @(negedge ref_clk);
    check({7'h00, busy}, 8'h00);
    check({7'h00, last_run >= PROG_P - 8 && last_run <= PROG_P + 8}, 8'h01);
  endtask

  task automatic no_prog();
    repeat (20) @(negedge ref_clk);
    check({7'h00, busy}, 8'h00);
  endtask

  initial begin
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(negedge ref_clk);
    check({6'h00, busy, id_locked}, 8'h00);
    cmd(CMD_RECOVER, 8'h09, 1'b0);
    check({7'h00, rsp_ack}, 8'h01);
    cmd(CMD_START, 8'h00, 1'b0);
    wr({TYPE_ARRAY, STRAPS ^ 3'h1, 1'b0}, 1'b0);
    cmd(CMD_START, 8'h00, 1'b0);
    wr({4'h9, STRAPS, 1'b0}, 1'b0);
    cmd(CMD_STOP, 8'h00, 1'b0);
    @(posedge ref_clk);
    straps <= 3'h2;
    cmd(CMD_START, 8'h00, 1'b0);
    wr({TYPE_ARRAY, 3'h2, 1'b0}, 1'b1);
    cmd(CMD_STOP, 8'h00, 1'b0);
    @(posedge ref_clk);
    straps <= STRAPS;
    // three bytes from the second-last offset: the third wraps to the page start
    head(TYPE_ARRAY, 16'h12fe);
    wr(8'ha1, 1'b1);
    wr(8'ha2, 1'b1);
    wr(8'ha3, 1'b1);
    cmd(CMD_STOP, 8'h00, 1'b0);
    busy_on();
    cmd(CMD_START, 8'h00, 1'b0);
    wr({TYPE_ARRAY, STRAPS, 1'b0}, 1'b0);
    busy_off();
    cmd(CMD_START, 8'h00, 1'b0);
    wr({TYPE_ARRAY, STRAPS, 1'b0}, 1'b1);
    cmd(CMD_STOP, 8'h00, 1'b0);
    head(TYPE_ARRAY, 16'h12fe);
    rd_sel(TYPE_ARRAY);
    rd(1'b0, 8'ha1);
    rd(1'b1, 8'ha2);
    cmd(CMD_STOP, 8'h00, 1'b0);
    head(TYPE_ARRAY, 16'h1280);
    rd_sel(TYPE_ARRAY);
    rd(1'b1, 8'ha3);
    cmd(CMD_STOP, 8'h00, 1'b0);
    // protected write is acknowledged but leaves the array alone
    @(posedge ref_clk);
    wp <= 1'b1;
    head(TYPE_ARRAY, 16'h12fe);
    wr(8'h55, 1'b1);
    cmd(CMD_STOP, 8'h00, 1'b0);
    no_prog();
    @(posedge ref_clk);
    wp <= 1'b0;
    head(TYPE_ARRAY, 16'h12fe);
    rd_sel(TYPE_ARRAY);
    rd(1'b1, 8'ha1);
    cmd(CMD_STOP, 8'h00, 1'b0);
    // id page: upper address bits other than the select bit are ignored
    head(TYPE_IDPAGE, 16'hfb05);
    wr(8'h3c, 1'b1);
    cmd(CMD_STOP, 8'h00, 1'b0);
    busy_on();
    busy_off();
    head(TYPE_IDPAGE, 16'h0085);
    rd_sel(TYPE_IDPAGE);
    rd(1'b1, 8'h3c);
    cmd(CMD_STOP, 8'h00, 1'b0);
    head(TYPE_IDPAGE, 16'h0400);
    wr(8'h02, 1'b1);
    cmd(CMD_STOP, 8'h00, 1'b0);
    busy_on();
    busy_off();
    check({7'h00, id_locked}, 8'h01);
    head(TYPE_IDPAGE, 16'h0006);
    wr(8'h77, 1'b0);
    cmd(CMD_STOP, 8'h00, 1'b0);
    no_prog();
    // second reset in mid-run clears the lock
    @(posedge ref_clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(negedge ref_clk);
    check({6'h00, busy, id_locked}, 8'h00);
    finish_test();
  end

  // a hung handshake or busy flag would otherwise stall the run
  initial begin
    repeat (90000) @(posedge ref_clk);
    failures++;
    finish_test();
  end
endmodule
